// file: verilog/dac_link_pkg.sv
/*
   Shared constants and carrier types for the serial load and clear front end of a
   four-channel output converter.
   Assumes a single reference clock domain; every pin is synchronised by the user of this package.
*/
`default_nettype none

package dac_link_pkg;

   // Converter geometry.
   localparam int NUM_CHAN = 4;
   localparam int CODE_W = 16;
   localparam int CHAN_W = 2;

   // Frame lengths in shift clock falling edges.
   localparam int FRAME_BITS = 24;
   localparam int FRAME_BITS_CHECK = 32;
   localparam int SHIFT_W = 32;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] CNT_FRAME = 6'h18;
   localparam logic [CNT_W-1:0] CNT_FRAME_CHECK = 6'h20;
   localparam logic [CNT_W-1:0] CNT_SATURATE = 6'h3F;

   // Reference clock and the fastest shift clock the link accepts.
   localparam int REF_CLK_MHZ = 250;
   localparam int SHIFT_CLK_MAX_MHZ = 30;

   // Position of each synchronised pin in the input vector.
   localparam int PIN_COUNT = 7;
   localparam int PIN_FRAME = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_SDI = 2;
   localparam int PIN_LOAD = 3;
   localparam int PIN_CLEAR = 4;
   localparam int PIN_ADDR_LO = 5;
   localparam int PIN_ADDR_HI = 6;

   // Idle level of each pin while synchronisers are in reset.
   localparam logic [PIN_COUNT-1:0] PIN_IDLE = 7'h09;

   // Field positions inside a configuration data word.
   localparam int CFG_PACKET_CHECK_BIT = 0;

   // Reset values.
   localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
   localparam logic [CODE_W-1:0] CLEAR_CODE_RESET = 16'h0000;
   localparam logic [NUM_CHAN-1:0] CLEAR_EN_RESET = 4'h0;
   localparam logic PACKET_CHECK_RESET = 1'b0;

   // Frame commands.
   typedef enum logic [2:0] {
      CMD_INPUT = 3'b000,
      CMD_CLEAR_CODE = 3'b001,
      CMD_CLEAR_EN = 3'b010,
      CMD_CONFIG = 3'b011,
      CMD_OUTPUT = 3'b100
   } cmd_e;

   // One 24-bit frame, first bit shifted in is the read flag.
   typedef struct packed {
      logic read;
      logic [1:0] dev_addr;
      cmd_e cmd;
      logic [CHAN_W-1:0] chan;
      logic [CODE_W-1:0] data;
   } frame_s;

   // A buffered frame together with its update mode captured at frame end.
   typedef struct packed {
      frame_s frame;
      logic immediate;
   } entry_s;

   typedef logic [NUM_CHAN-1:0][CODE_W-1:0] code_bank_t;

endpackage

`default_nettype wire

// file: verilog/dac_serial_load_clear_ctrl.sv
/*
   Digital front end of a four-channel output converter: framed serial input with
   device address match, readback on the serial output, immediate or strobed DAC
   update, and edge-triggered clear of enabled channels.
   Assumes ref_clk is at least eight times the shift clock rate and that every pin
   is asynchronous to ref_clk; all pins pass a two-stage synchroniser first.
*/
// Summary of operation
// - Shift in one bit per falling clock while framed.
// - Logic keeps up with shift clock to limit.
// - Readback word shifts out on serial output.
// - Load low: update output at frame end.
// - Load high: input register only, defer output.
// - Load falling edge transfers all pending channels.
// - Clear rising edge loads programmed clear code.
// - Clear touches only channels with enable set.
// - Active clear blocks frame and load output register writes.
// - Address pins compared with frame address.
// - Frame is 24 edges, 32 with checking.
// - Active-low reset restores power-on state.
`timescale 1ns/10ps
`default_nettype none

module dac_serial_load_clear_ctrl #(
   parameter int FIFO_DEPTH = 2,
   parameter int FIFO_W = $bits(dac_link_pkg::entry_s)
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // Serial link from the host.
   input wire logic frame_sel_n,
   input wire logic shift_clk,
   input wire logic serial_in,
   output logic serial_out,
   // Update and clear controls.
   input wire logic load_strobe_n,
   input wire logic clear,
   // Board address straps.
   input wire logic addr_select_lo,
   input wire logic addr_select_hi,
   // Converter side.
   output dac_link_pkg::code_bank_t dac_code,
   output logic [dac_link_pkg::NUM_CHAN-1:0] dac_update,
   output logic clear_active,
   output logic packet_check,
   output logic frame_dropped
);
   import dac_link_pkg::*;

   localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
   localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(FIFO_DEPTH);
   localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);
   localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

   // Pin synchronisers.
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_meta_reg;
   logic [PIN_COUNT-1:0] pin_sync_reg;
   logic [PIN_COUNT-1:0] pin_prev_reg;

   // Shift register state.
   logic [SHIFT_W-1:0] shift_reg;
   logic [CNT_W-1:0] bit_cnt_reg;

   // Buffer state.
   logic [FIFO_W-1:0] fifo_mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [LVL_W-1:0] level_reg;

   // Channel and configuration state.
   code_bank_t input_reg;
   code_bank_t output_reg;
   code_bank_t clear_code_reg;
   logic [NUM_CHAN-1:0] clear_en_reg;
   logic [NUM_CHAN-1:0] pending_reg;
   logic [NUM_CHAN-1:0] update_reg;
   logic packet_check_reg;
   logic dropped_reg;

   // Readback state.
   frame_s rb_word_reg;
   logic rb_armed_reg;
   logic [FRAME_BITS-1:0] rb_shift_reg;

   assign pin_raw = {addr_select_hi, addr_select_lo, clear, load_strobe_n, serial_in, shift_clk, frame_sel_n};

   // reset to idle.
   // The first stage is read only by the second stage; edges are found on later stages.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pin_meta_reg <= PIN_IDLE;
         pin_sync_reg <= PIN_IDLE;
         pin_prev_reg <= PIN_IDLE;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // Edge and level decode of synchronised pins.
   wire framed = ~pin_sync_reg[PIN_FRAME];
   wire frame_start = pin_prev_reg[PIN_FRAME] & ~pin_sync_reg[PIN_FRAME];
   wire frame_end = ~pin_prev_reg[PIN_FRAME] & pin_sync_reg[PIN_FRAME];
   wire sclk_fall = pin_prev_reg[PIN_SCLK] & ~pin_sync_reg[PIN_SCLK];
   wire sclk_rise = ~pin_prev_reg[PIN_SCLK] & pin_sync_reg[PIN_SCLK];
   wire load_low = ~pin_sync_reg[PIN_LOAD];
   wire load_fall = pin_prev_reg[PIN_LOAD] & ~pin_sync_reg[PIN_LOAD];
   wire clear_level = pin_sync_reg[PIN_CLEAR];
   wire clear_rise = ~pin_prev_reg[PIN_CLEAR] & pin_sync_reg[PIN_CLEAR];
   wire [1:0] board_addr = {pin_sync_reg[PIN_ADDR_HI], pin_sync_reg[PIN_ADDR_LO]};

   // framed bit capture.
   // Data and shift clock share one synchroniser delay, so the sampled bit is the one
   // the host held at the falling edge; at most 30 MHz leaves four ref_clk cycles per phase.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         shift_reg <= '0;
         bit_cnt_reg <= '0;
      end else if (frame_start) begin
         bit_cnt_reg <= '0;
      end else if (framed && sclk_fall) begin
         shift_reg <= {shift_reg[SHIFT_W-2:0], pin_sync_reg[PIN_SDI]};
         if (bit_cnt_reg != CNT_SATURATE) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
      end
   end

   wire [CNT_W-1:0] expected_bits = packet_check_reg ? CNT_FRAME_CHECK : CNT_FRAME;
   wire frame_ok = frame_end & (bit_cnt_reg == expected_bits);
   // The check byte of a 32-edge frame trails the 24-bit payload and is not verified here.
   wire [FRAME_BITS-1:0] rx_bits = packet_check_reg ? shift_reg[SHIFT_W-1:SHIFT_W-FRAME_BITS]
                                                   : shift_reg[FRAME_BITS-1:0];
   frame_s rx_frame;
   assign rx_frame = frame_s'(rx_bits);

   wire addr_match = rx_frame.dev_addr == board_addr;
   wire push_valid = frame_ok & addr_match;

   // immediate mode sampled at frame end.
   // clear at frame end blocks the update.
   entry_s push_entry;
   assign push_entry = '{frame: rx_frame, immediate: load_low & ~clear_level};

   // Buffer handshake; the drain stalls while clear is active.
   wire push_ready = level_reg != LVL_FULL;
   wire pop_valid = level_reg != '0;
   wire pop_ready = ~clear_level;
   wire push = push_valid & push_ready;
   wire pop = pop_valid & pop_ready;
   entry_s head;
   assign head = entry_s'(fifo_mem[rd_ptr_reg]);

   always_ff @(posedge ref_clk) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= FIFO_W'(push_entry);
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         level_reg <= '0;
         dropped_reg <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_ONE;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_ONE;
         end
         if (push && !pop) begin
            level_reg <= level_reg + LVL_ONE;
         end else if (pop && !push) begin
            level_reg <= level_reg - LVL_ONE;
         end
         dropped_reg <= push_valid & ~push_ready;
      end
   end

   // Decode of the word leaving the buffer.
   wire head_write = pop & ~head.frame.read;
   wire head_read = pop & head.frame.read;
   wire wr_clear_code = head_write & (head.frame.cmd == CMD_CLEAR_CODE);
   wire wr_clear_en = head_write & (head.frame.cmd == CMD_CLEAR_EN);
   wire wr_config = head_write & (head.frame.cmd == CMD_CONFIG);
   wire wr_input = head_write & (head.frame.cmd == CMD_INPUT);
   wire xfer_all = load_fall & ~clear_level;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch = ch + 1) begin : g_chan
         wire sel = head.frame.chan == CHAN_W'(ch);
         wire wr_in_ch = wr_input & sel;
         wire [CODE_W-1:0] in_next = wr_in_ch ? head.frame.data : input_reg[ch];
         wire xfer_ch = xfer_all & (pending_reg[ch] | (wr_in_ch & ~head.immediate));
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               input_reg[ch] <= CODE_RESET;
               output_reg[ch] <= CODE_RESET;
               clear_code_reg[ch] <= CLEAR_CODE_RESET;
               pending_reg[ch] <= 1'b0;
               update_reg[ch] <= 1'b0;
            end else begin
               input_reg[ch] <= in_next;
               update_reg[ch] <= 1'b0;
               if (wr_clear_code && sel) begin
                  clear_code_reg[ch] <= head.frame.data;
               end
               if (clear_rise) begin
                  if (clear_en_reg[ch]) begin
                     output_reg[ch] <= clear_code_reg[ch];
                     update_reg[ch] <= 1'b1;
                  end
               end else if (xfer_ch) begin
                  output_reg[ch] <= in_next;
                  update_reg[ch] <= 1'b1;
               end else if (wr_in_ch && head.immediate) begin
                  output_reg[ch] <= head.frame.data;
                  update_reg[ch] <= 1'b1;
               end
               if (xfer_ch) begin
                  pending_reg[ch] <= 1'b0;
               end else if (wr_in_ch && !head.immediate) begin
                  pending_reg[ch] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // Configuration registers written through frames.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         clear_en_reg <= CLEAR_EN_RESET;
         packet_check_reg <= PACKET_CHECK_RESET;
      end else begin
         if (wr_clear_en) begin
            clear_en_reg <= head.frame.data[NUM_CHAN-1:0];
         end
         if (wr_config) begin
            packet_check_reg <= head.frame.data[CFG_PACKET_CHECK_BIT];
         end
      end
   end

   // Readback source selection.
   logic [CODE_W-1:0] rb_data;
   always_comb begin
      rb_data = '0;
      unique case (head.frame.cmd)
         CMD_INPUT: rb_data = input_reg[head.frame.chan];
         CMD_CLEAR_CODE: rb_data = clear_code_reg[head.frame.chan];
         CMD_CLEAR_EN: rb_data = CODE_W'(clear_en_reg);
         CMD_CONFIG: rb_data = CODE_W'(packet_check_reg);
         CMD_OUTPUT: rb_data = output_reg[head.frame.chan];
         default: rb_data = '0;
      endcase
   end

   // readback word shifted out.
   // A read frame arms one word; the next frame carries it out MSB first, one bit
   // per rising shift clock, so the host samples each bit at the following fall.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rb_word_reg <= '0;
         rb_armed_reg <= 1'b0;
         rb_shift_reg <= '0;
      end else begin
         if (head_read) begin
            rb_word_reg <= '{read: 1'b1, dev_addr: head.frame.dev_addr, cmd: head.frame.cmd,
                             chan: head.frame.chan, data: rb_data};
            rb_armed_reg <= 1'b1;
         end else if (frame_start) begin
            rb_armed_reg <= 1'b0;
         end
         if (frame_start) begin
            rb_shift_reg <= rb_armed_reg ? FRAME_BITS'(rb_word_reg) : '0;
         end else if (frame_end) begin
            rb_shift_reg <= '0;
         end else if (framed && sclk_rise && bit_cnt_reg != '0) begin
            rb_shift_reg <= {rb_shift_reg[FRAME_BITS-2:0], 1'b0};
         end
      end
   end

   // Outputs.
   assign serial_out = rb_shift_reg[FRAME_BITS-1];
   assign dac_code = output_reg;
   assign dac_update = update_reg;
   assign clear_active = pin_sync_reg[PIN_CLEAR];
   assign packet_check = packet_check_reg;
   assign frame_dropped = dropped_reg;

endmodule

`default_nettype wire

// file: verification/dac_host_model.sv
/*
   Host side of the framed serial link: sends frames and captures readback bits.
   Assumes ref_clk only to align the first edge; all later delays keep that phase.
*/
`timescale 1ns/10ps
`default_nettype none

module dac_host_model (
   // Alignment clock.
   input wire logic ref_clk,
   // Link pins.
   output logic frame_sel_n,
   output logic shift_clk,
   output logic serial_in,
   input wire logic serial_out
);
   logic [31:0] rd_word = 32'h0;
   initial begin
      frame_sel_n = 1'b1;
      shift_clk = 1'b1;
      serial_in = 1'b0;
   end
   task automatic xfer(input logic [31:0] bits, input int n);
      @(posedge ref_clk);
      #1 frame_sel_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = bits[i];
         #24 rd_word[i] = serial_out;
         shift_clk = 1'b0;
         #24 shift_clk = 1'b1;
      end
      #24 frame_sel_n = 1'b1;
      // A released line shows the inverse, so a stale bit never passes as valid.
      serial_in = ~serial_in;
      #40;
   endtask
endmodule

`default_nettype wire

// file: verification/dac_ctrl_checker.sv
/*
   Concurrent checks on the ports of the serial load and clear front end.
   Assumes one ref_clk domain; bound to the design at the foot of this file.
*/
`timescale 1ns/10ps
`default_nettype none

module dac_ctrl_checker #(
   parameter int FIFO_DEPTH = 2,
   parameter int FIFO_W = $bits(dac_link_pkg::entry_s)
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // Pins.
   input wire logic frame_sel_n,
   input wire logic shift_clk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic load_strobe_n,
   input wire logic clear,
   input wire logic addr_select_lo,
   input wire logic addr_select_hi,
   // Converter side.
   input wire dac_link_pkg::code_bank_t dac_code,
   input wire logic [dac_link_pkg::NUM_CHAN-1:0] dac_update,
   input wire logic clear_active,
   input wire logic packet_check,
   input wire logic frame_dropped
);
   import dac_link_pkg::*;
   logic [5:0] cause_reg;
   logic [5:0] framed_reg;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Six samples of history cover the synchroniser and buffer latency.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cause_reg <= 6'h00;
         framed_reg <= 6'h00;
      end else begin
         cause_reg <= {cause_reg[4:0], ~load_strobe_n | clear};
         framed_reg <= {framed_reg[4:0], ~frame_sel_n};
      end
   end
   sequence gap_s;
      !frame_sel_n ##1 frame_sel_n [*5];
   endsequence
   sequence clear_held_s;
      clear [*6];
   endsequence
   for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
      chk_code_pulse: assert property (dac_code[i] != $past(dac_code[i]) |-> dac_update[i])
         else $error("Code changed without pulse.");
   end
   chk_joint_update: assert property ($countones(dac_update) > 1 |-> |cause_reg)
      else $error("Joint update without load or clear.");
   chk_clear_block: assert property (clear_held_s |-> dac_update == 4'h0)
      else $error("Output written during clear.");
   chk_clear_sync: assert property (clear [*4] |-> clear_active)
      else $error("Clear level not seen.");
   chk_clear_idle: assert property ((!clear) [*4] |-> !clear_active)
      else $error("Clear level stuck.");
   chk_out_idle: assert property (gap_s |-> !serial_out)
      else $error("Serial output not idle.");
   chk_out_framed: assert property ($changed(serial_out) |-> |framed_reg)
      else $error("Serial output moved outside frame.");
   chk_mode_change: assert property ($changed(packet_check) |-> $past(frame_sel_n, 2) && $past(frame_sel_n, 3))
      else $error("Mode changed inside frame.");
   chk_drop_pulse: assert property (frame_dropped |-> $past(clear_active) ##1 !frame_dropped)
      else $error("Bad drop pulse.");
endmodule

bind dac_serial_load_clear_ctrl dac_ctrl_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_W(FIFO_W)) u_checker (
   .ref_clk(ref_clk), .resetn(resetn), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
   .serial_in(serial_in), .serial_out(serial_out), .load_strobe_n(load_strobe_n), .clear(clear),
   .addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi), .dac_code(dac_code),
   .dac_update(dac_update), .clear_active(clear_active), .packet_check(packet_check),
   .frame_dropped(frame_dropped)
);

`default_nettype wire

// file: verification/test_dac_serial_load_clear_ctrl.sv
/*
   Self-checking bench for the serial load and clear front end.
   Assumes the host model drives the link; update, clear and straps are driven here.
*/
`timescale 1ns/10ps
`default_nettype none

module test_dac_serial_load_clear_ctrl;
   import dac_link_pkg::*;
   logic ref_clk;
   logic resetn;
   logic load_strobe_n;
   logic clear;
   logic addr_select_lo;
   logic addr_select_hi;
   wire logic frame_sel_n;
   wire logic shift_clk;
   wire logic serial_in;
   logic serial_out;
   logic clear_active;
   logic packet_check;
   logic frame_dropped;
   code_bank_t dac_code;
   logic [NUM_CHAN-1:0] dac_update;
   logic [NUM_CHAN-1:0] upd_last;
   logic [CODE_W-1:0] exp_code [NUM_CHAN];
   int num_errors = 0;
   int n_compared = 0;
   int n_drop = 0;

   dac_host_model host (.ref_clk(ref_clk), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
      .serial_in(serial_in), .serial_out(serial_out));
   dac_serial_load_clear_ctrl #(.FIFO_DEPTH(2)) DUT (
      .ref_clk(ref_clk), .resetn(resetn), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
      .serial_in(serial_in), .serial_out(serial_out), .load_strobe_n(load_strobe_n), .clear(clear),
      .addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi), .dac_code(dac_code),
      .dac_update(dac_update), .clear_active(clear_active), .packet_check(packet_check),
      .frame_dropped(frame_dropped));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (dac_update !== 4'h0)
         upd_last <= dac_update;
      if (frame_dropped === 1'b1)
         n_drop <= n_drop + 1;
   end

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   function automatic logic [23:0] fr(input logic rd, input cmd_e c, input logic [1:0] ch, input logic [15:0] d);
      return {rd, addr_select_hi, addr_select_lo, c, ch, d};
   endfunction
   task automatic send(input logic [23:0] w);
      host.xfer({8'h00, w}, 24);
   endtask
   task automatic codes_ok();
      for (int i = 0; i < NUM_CHAN; i++)
         cmp("dac_code", {16'h0, exp_code[i]}, {16'h0, dac_code[i]});
   endtask
   task automatic load_pulse();
      load_strobe_n = 1'b1;
      tick(2);
      load_strobe_n = 1'b0;
      tick(8);
   endtask

   task automatic t_immediate();
      for (int i = 0; i < NUM_CHAN; i++) begin
         upd_last = 4'h0;
         exp_code[i] = 16'(16'h1111 * (i + 1));
         send(fr(1'b0, CMD_INPUT, 2'(i), exp_code[i]));
         codes_ok();
         cmp("dac_update", 32'(4'h1 << i), {28'h0, upd_last});
      end
   endtask
   task automatic t_address();
      send({1'b0, ~addr_select_hi, ~addr_select_lo, CMD_INPUT, 2'h0, 16'hDEAD});
      host.xfer({8'h00, fr(1'b0, CMD_INPUT, 2'h1, 16'hDEAD)}, 23);
      codes_ok();
      addr_select_lo = 1'b1;
      tick(4);
      exp_code[1] = 16'h4321;
      send(fr(1'b0, CMD_INPUT, 2'h1, 16'h4321));
      codes_ok();
   endtask
   task automatic t_deferred();
      load_strobe_n = 1'b1;
      tick(4);
      send(fr(1'b0, CMD_INPUT, 2'h0, 16'hA0A0));
      send(fr(1'b0, CMD_INPUT, 2'h2, 16'hC2C2));
      codes_ok();
      upd_last = 4'h0;
      load_strobe_n = 1'b0;
      tick(8);
      exp_code[0] = 16'hA0A0;
      exp_code[2] = 16'hC2C2;
      codes_ok();
      cmp("dac_update", 32'h5, {28'h0, upd_last});
   endtask
   task automatic t_clear();
      send(fr(1'b0, CMD_CLEAR_CODE, 2'h1, 16'h5A5A));
      send(fr(1'b0, CMD_CLEAR_EN, 2'h0, 16'h0002));
      clear = 1'b1;
      tick(8);
      exp_code[1] = 16'h5A5A;
      cmp("clear_active", 32'h1, {31'h0, clear_active});
      codes_ok();
      n_drop = 0;
      send(fr(1'b0, CMD_INPUT, 2'h3, 16'h3333));
      send(fr(1'b0, CMD_INPUT, 2'h0, 16'h0F0F));
      send(fr(1'b0, CMD_INPUT, 2'h2, 16'h2222));
      load_pulse();
      codes_ok();
      cmp("frame_dropped", 32'h1, 32'(n_drop));
      clear = 1'b0;
      tick(8);
      codes_ok();
      upd_last = 4'h0;
      load_pulse();
      exp_code[3] = 16'h3333;
      exp_code[0] = 16'h0F0F;
      codes_ok();
      cmp("dac_update", 32'h9, {28'h0, upd_last});
   endtask
   task automatic t_readback();
      send(fr(1'b1, CMD_OUTPUT, 2'h3, 16'h0000));
      send(fr(1'b0, CMD_OUTPUT, 2'h3, 16'hFFFF));
      cmp("readback", {8'h0, fr(1'b1, CMD_OUTPUT, 2'h3, exp_code[3])}, {8'h0, host.rd_word[23:0]});
      cmp("serial_out", 32'h0, {31'h0, serial_out});
      codes_ok();
      send(fr(1'b1, CMD_CLEAR_EN, 2'h0, 16'h0000));
      send(fr(1'b1, CMD_INPUT, 2'h2, 16'h0000));
      cmp("readback", {8'h0, fr(1'b1, CMD_CLEAR_EN, 2'h0, 16'h0002)}, {8'h0, host.rd_word[23:0]});
      send(fr(1'b0, CMD_OUTPUT, 2'h0, 16'h0000));
      cmp("readback", {8'h0, fr(1'b1, CMD_INPUT, 2'h2, exp_code[2])}, {8'h0, host.rd_word[23:0]});
   endtask
   task automatic t_check_mode();
      send(fr(1'b0, CMD_CONFIG, 2'h0, 16'h0001));
      cmp("packet_check", 32'h1, {31'h0, packet_check});
      send(fr(1'b0, CMD_INPUT, 2'h1, 16'h7777));
      host.xfer({fr(1'b0, CMD_INPUT, 2'h2, 16'h7171), 8'h3C}, 32);
      exp_code[2] = 16'h7171;
      codes_ok();
   endtask
   task automatic t_reset();
      resetn = 1'b0;
      tick(3);
      exp_code = '{default: CODE_RESET};
      codes_ok();
      cmp("packet_check", 32'h0, {31'h0, packet_check});
      resetn = 1'b1;
      tick(4);
   endtask

   task automatic final_report();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      resetn = 1'b0;
      load_strobe_n = 1'b0;
      clear = 1'b0;
      upd_last = 4'h0;
      exp_code = '{default: CODE_RESET};
      addr_select_lo = 1'b0;
      addr_select_hi = 1'b1;
      tick(6);
      resetn = 1'b1;
      tick(4);
      t_immediate();
      t_address();
      t_deferred();
      t_clear();
      t_readback();
      t_check_mode();
      t_reset();
      final_report();
   end
   // About 22 frames of 1.2 us each; the limit leaves ample margin.
   initial begin
      #200000;
      num_errors++;
      final_report();
   end
endmodule

`default_nettype wire
